//--- hdl/qdl_pkg.sv
/*
  Constants and carrier types for the qudit discrimination result logger.
  Assumes one processing clock shared by every user of these types.
*/
`default_nettype none
package qdl_pkg;
  localparam int NQ   = 16;
  localparam int NB   = 32;
  localparam int NINT = 16;
  localparam int NTHR = 6;
  localparam int CW   = 6;
  localparam int DW   = 16;
  localparam int SW   = 32;
  localparam logic [2:0] STATES_MIN = 3'h2;
  localparam logic [2:0] STATES_MAX = 3'h4;
  localparam logic [CW-1:0] SRC_QUDIT_LAST = 6'h1F;
  localparam logic [CW-1:0] SRC_FIXED0 = 6'h20;
  localparam logic [CW-1:0] SRC_FIXED1 = 6'h21;
  localparam logic MODE_CYCLIC = 1'h0;
  localparam logic MODE_SEQUENTIAL = 1'h1;
  localparam logic [1:0] LOG_SRC_INTEG = 2'h1;
  localparam logic [1:0] LOG_SRC_DISC = 2'h3;
  localparam logic signed [DW-1:0] WEIGHT_POS_ONE = 16'sh7FFF;
  localparam logic signed [DW-1:0] WEIGHT_NEG_ONE = 16'sh8001;

  typedef enum logic [1:0] {
    LG_IDLE,
    LG_ARMED,
    LG_BUSY,
    LG_DONE
  } qdl_log_state_type;

  // One projection per used integrator of the qudit, plus the imaginary
  // part of the first one for the complex logger source.
  typedef struct packed {
    logic                          valid;
    logic [3:0]                    qudit;
    logic [2:0][DW-1:0]            proj_re;
    logic signed [DW-1:0]          proj_im;
  } qdl_disc_in_type;

  typedef struct packed {
    logic                 valid;
    logic [3:0]           qudit;
    logic [1:0]           wave;
    logic signed [DW-1:0] re;
    logic signed [DW-1:0] im;
  } qdl_weight_type;

  typedef struct packed {
    logic signed [SW-1:0] re;
    logic signed [SW-1:0] im;
  } qdl_sample_type;
endpackage
`default_nettype wire

//--- hdl/qdl_result_logger.sv
/*
  Qudit discrimination configuration checker, link bit mapper and readout
  result logger for one analyzer channel.
  Assumes all inputs come from logic on clk; trigger is a one-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE_01: State count counts as valid only from two to four inclusive.
// RULE_02: Only the first d(d-1)/2 thresholds take part in discrimination.
// RULE_03: Only weight waves below d-1 pass; samples clamp to plus/minus one.
// RULE_04: Configuration valid only when enabled qudits fit the integrators.
// RULE_05: Each qudit reports its first integrator and its integrator list.
// RULE_06: Link source code 2q+b carries bit b of qudit q, codes 0 to 31.
// RULE_07: Codes 32 and 33 drive constant zero or one, flagged invalid.
// RULE_08: Packed mode assigns bits by qudit order, one or two per qudit.
// RULE_09: In packed mode writes to the per-bit sources are ignored.
// RULE_10: Acquired index names the acquisition the next trigger performs.
// RULE_11: A configurable number of measurements is averaged per point.
// RULE_12: A configurable number of data points is recorded.
// RULE_13: Stored data is complex or integer depending on the source.
// RULE_14: Results are taken only while acquisition is enabled.
// RULE_15: Hold-off errors are counted and the count is visible.
// RULE_16: Job index of the latest hold-off error is latched.
// RULE_17: Any error-clear write zeroes the hold-off error count; a hold-off error in the same cycle still counts, leaving one.
// RULE_18: Mode 0 averages whole sequences, mode 1 each point in turn.
// RULE_19: Logger source 1 is integration, 3 is discrimination.
// RULE_20: A trigger while busy counts a hold-off error and is dropped.
module qdl_result_logger #(
  parameter int MEM_DEPTH = 1024
) (
  input  wire logic                                clk,
  input  wire logic                                reset_n,
  input  wire logic                                clk_en,
  input  wire logic                                ms_enable,
  input  wire logic [qdl_pkg::NQ-1:0]              qudit_enable,
  input  wire logic [qdl_pkg::NQ-1:0][2:0]         num_states,
  input  wire logic [qdl_pkg::NQ-1:0][qdl_pkg::NTHR-1:0][qdl_pkg::DW-1:0] thresholds,
  input  wire qdl_pkg::qdl_disc_in_type            disc_in,
  input  wire qdl_pkg::qdl_weight_type             weight_in,
  output qdl_pkg::qdl_weight_type                  weight_out,
  output logic [qdl_pkg::NQ-1:0][1:0]              qudit_state,
  output logic [qdl_pkg::NQ-1:0]                   states_ok,
  output logic                                     config_valid,
  output logic [qdl_pkg::NQ-1:0]                   qudit_available,
  output logic [qdl_pkg::NQ-1:0][4:0]              integ_start,
  output logic [qdl_pkg::NQ-1:0][qdl_pkg::NINT-1:0] integ_list,
  output logic [5:0]                               integ_count,
  input  wire logic                                packed_mode,
  input  wire logic                                src_wr,
  input  wire logic [4:0]                          src_wr_bit,
  input  wire logic [qdl_pkg::CW-1:0]              src_wr_code,
  output logic [qdl_pkg::NB-1:0][qdl_pkg::CW-1:0]  link_source,
  output logic [qdl_pkg::NB-1:0]                   link_bits,
  output logic [qdl_pkg::NB-1:0]                   link_valid,
  input  wire logic                                result_enable,
  input  wire logic                                result_mode,
  input  wire logic [1:0]                          result_source,
  input  wire logic [3:0]                          result_qudit,
  input  wire logic [31:0]                         result_averages,
  input  wire logic [15:0]                         result_length,
  input  wire logic                                trigger,
  input  wire logic                                error_clear,
  input  wire logic [15:0]                         rd_addr,
  output qdl_pkg::qdl_sample_type                  rd_data,
  output logic [31:0]                              acquired,
  output logic                                     result_done,
  output logic                                     result_busy,
  output logic [31:0]                              error_count,
  output logic [31:0]                              error_job
);
  import qdl_pkg::*;

  localparam int MAW = $clog2(MEM_DEPTH);

  typedef struct packed {
    logic [NB-1:0][CW-1:0]   src;
    logic [NB-1:0]           lbits;
    logic [NB-1:0]           lvalid;
    logic [NQ-1:0][1:0]      qstate;
    logic [NQ-1:0]           sok;
    logic                    cfg_valid;
    logic [NQ-1:0]           avail;
    logic [NQ-1:0][4:0]      start;
    logic [NQ-1:0][NINT-1:0] ilist;
    logic [5:0]              icount;
    qdl_weight_type          wout;
    qdl_sample_type          rdata;
    qdl_log_state_type       lg;
    logic [31:0]             acq;
    logic [15:0]             pt;
    logic [31:0]             rep;
    logic [31:0]             err_cnt;
    logic [31:0]             err_job;
    logic                    done;
  } qdl_state_type;

  qdl_state_type  r_reg;
  qdl_state_type  r_next;
  qdl_sample_type mem [MEM_DEPTH];
  logic           mem_we;
  logic [MAW-1:0] mem_addr;
  qdl_sample_type mem_wd;

  function automatic logic state_count_ok(input logic [2:0] d);
    return (d >= STATES_MIN) && (d <= STATES_MAX); // [RULE_01]
  endfunction

  function automatic logic signed [DW-1:0] clamp_w(input logic signed [DW-1:0] v);
    // Full-scale negative is one code beyond minus one, so it is pulled in.
    return (v < WEIGHT_NEG_ONE) ? WEIGHT_NEG_ONE : v; // [RULE_03]
  endfunction

  function automatic logic [NB-1:0][CW-1:0] packed_map(
    input logic [NQ-1:0]      en,
    input logic [NQ-1:0][2:0] d
  );
    logic [NB-1:0][CW-1:0] m;
    int                    pos;
    m   = {NB{SRC_FIXED0}};
    pos = 0;
    for (int q = 0; q < NQ; q++) begin
      if (en[q] && state_count_ok(d[q])) begin
        for (int b = 0; b < 2; b++) begin
          // Two-state qudits take one bit, larger ones take two.
          if ((b == 0 || d[q] > STATES_MIN) && pos < NB) begin // [RULE_08]
            m[pos] = CW'(2 * q + b);
            pos    = pos + 1;
          end
        end
      end
    end
    return m;
  endfunction

  function automatic logic [31:0] at_least_one(input logic [31:0] v);
    return (v == 32'h0) ? 32'h1 : v;
  endfunction

  always_comb begin
    int             acc;
    int             need;
    int             nthr;
    int             cnt;
    int             dm1;
    logic           bad;
    logic           hit;
    logic           fin;
    logic [2:0]     d;
    logic [CW-1:0]  c;
    logic [31:0]    avg;
    logic [15:0]    len;
    qdl_sample_type smp;
    acc      = 0;
    need     = 0;
    nthr     = 0;
    cnt      = 0;
    dm1      = 1;
    bad      = 1'b0;
    hit      = 1'b0;
    fin      = 1'b0;
    d        = 3'h0;
    c        = '0;
    avg      = at_least_one(result_averages);
    len      = 16'(at_least_one({16'h0, result_length}));
    smp      = '0;
    r_next   = r_reg;
    mem_we   = 1'b0;
    mem_addr = r_reg.pt[MAW-1:0];
    mem_wd   = '0;

    // Integrators are handed out in qudit order, d-1 to each enabled qudit.
    for (int q = 0; q < NQ; q++) begin
      d               = num_states[q];
      r_next.sok[q]   = state_count_ok(d); // [RULE_01]
      need            = state_count_ok(d) ? int'(d) - 1 : 0;
      r_next.start[q] = 5'(acc); // [RULE_05]
      r_next.avail[q] = state_count_ok(d) && (acc + need <= NINT);
      for (int i = 0; i < NINT; i++) begin
        r_next.ilist[q][i] = (i >= acc) && (i < acc + need); // [RULE_05]
      end
      if (ms_enable && qudit_enable[q]) begin
        acc = acc + need;
        bad = bad | ~state_count_ok(d);
      end
    end
    r_next.cfg_valid = ~bad && (acc <= NINT); // [RULE_04]
    r_next.icount    = 6'(acc);

    // Count thresholds passed, comparing each against a used projection.
    if (disc_in.valid && state_count_ok(num_states[disc_in.qudit])) begin
      d    = num_states[disc_in.qudit];
      dm1  = int'(d) - 1;
      nthr = int'(d) * dm1 / 2;
      for (int k = 0; k < NTHR; k++) begin
        if (k < nthr && $signed(disc_in.proj_re[k % dm1]) >
            $signed(thresholds[disc_in.qudit][k])) begin // [RULE_02]
          cnt = cnt + 1;
        end
      end
      r_next.qstate[disc_in.qudit] = 2'((cnt > dm1) ? dm1 : cnt);
    end

    r_next.wout.valid = 1'b0;
    if (weight_in.valid && state_count_ok(num_states[weight_in.qudit]) &&
        ({1'b0, weight_in.wave} < num_states[weight_in.qudit] - 3'h1)) begin
      r_next.wout       = weight_in; // [RULE_03]
      r_next.wout.re    = clamp_w(weight_in.re);
      r_next.wout.im    = clamp_w(weight_in.im);
    end

    if (packed_mode) begin
      r_next.src = packed_map(qudit_enable & {NQ{ms_enable}}, num_states); // [RULE_08]
    end else if (src_wr) begin
      r_next.src[src_wr_bit] = src_wr_code; // [RULE_09]
    end

    for (int i = 0; i < NB; i++) begin
      c = r_reg.src[i];
      if (c <= SRC_QUDIT_LAST) begin
        r_next.lbits[i]  = r_reg.qstate[c[4:1]][c[0]]; // [RULE_06]
        r_next.lvalid[i] = 1'b1;
      end else begin
        r_next.lbits[i]  = (c == SRC_FIXED1); // [RULE_07]
        r_next.lvalid[i] = 1'b0;
      end
    end

    // The clear comes first so that an error in the same cycle still counts.
    if (error_clear) begin
      r_next.err_cnt = 32'h0; // [RULE_17]
    end

    if (result_source == LOG_SRC_DISC) begin
      smp.re = SW'(r_next.qstate[result_qudit]); // [RULE_13] [RULE_19]
    end else begin
      smp.re = SW'($signed(disc_in.proj_re[0])); // [RULE_19]
      smp.im = SW'(disc_in.proj_im);
    end
    hit = disc_in.valid && (disc_in.qudit == result_qudit);

    unique case (r_reg.lg)
      LG_IDLE: begin
        if (result_enable) begin
          r_next.lg   = LG_ARMED;
          r_next.pt   = 16'h0;
          r_next.rep  = 32'h0;
          r_next.done = 1'b0;
        end
      end
      LG_ARMED: begin
        if (!result_enable) begin
          r_next.lg = LG_IDLE; // [RULE_14]
        end else if (trigger) begin
          r_next.lg = LG_BUSY;
        end
      end
      LG_BUSY: begin
        if (trigger) begin
          r_next.err_cnt = r_next.err_cnt + 32'h1; // [RULE_15] [RULE_20]
          r_next.err_job = r_reg.acq; // [RULE_16]
        end
        if (!result_enable) begin
          r_next.lg = LG_IDLE; // [RULE_14]
        end else if (hit) begin
          mem_we = 1'b1;
          if (r_reg.rep != 32'h0) begin
            mem_wd.re = mem[mem_addr].re + smp.re; // [RULE_11]
            mem_wd.im = mem[mem_addr].im + smp.im;
          end else begin
            mem_wd = smp;
          end
          r_next.acq = r_reg.acq + 32'h1; // [RULE_10]
          if (result_mode == MODE_CYCLIC) begin
            if (r_reg.pt == len - 16'h1) begin // [RULE_18]
              r_next.pt  = 16'h0;
              r_next.rep = r_reg.rep + 32'h1;
              fin        = (r_reg.rep == avg - 32'h1);
            end else begin
              r_next.pt = r_reg.pt + 16'h1;
            end
          end else begin
            if (r_reg.rep == avg - 32'h1) begin // [RULE_18]
              r_next.rep = 32'h0;
              r_next.pt  = r_reg.pt + 16'h1;
              fin        = (r_reg.pt == len - 16'h1); // [RULE_12]
            end else begin
              r_next.rep = r_reg.rep + 32'h1;
            end
          end
          r_next.lg   = fin ? LG_DONE : LG_ARMED;
          r_next.done = fin;
        end
      end
      LG_DONE: begin
        if (!result_enable) begin
          r_next.lg   = LG_IDLE;
          r_next.done = 1'b0;
        end
      end
    endcase

    r_next.rdata = mem[rd_addr[MAW-1:0]];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r_reg     <= '0;
      r_reg.lg  <= LG_IDLE;
      r_reg.src <= {NB{SRC_FIXED0}};
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  // Result memory has no reset; the first repetition overwrites each word.
  always_ff @(posedge clk) begin
    if (clk_en && mem_we) begin
      mem[mem_addr] <= mem_wd;
    end
  end

  assign weight_out      = r_reg.wout;
  assign qudit_state     = r_reg.qstate;
  assign states_ok       = r_reg.sok;
  assign config_valid    = r_reg.cfg_valid;
  assign qudit_available = r_reg.avail;
  assign integ_start     = r_reg.start;
  assign integ_list      = r_reg.ilist;
  assign integ_count     = r_reg.icount;
  assign link_source     = r_reg.src;
  assign link_bits       = r_reg.lbits;
  assign link_valid      = r_reg.lvalid;
  assign rd_data         = r_reg.rdata;
  assign acquired        = r_reg.acq;
  assign result_done     = r_reg.done;
  assign result_busy     = (r_reg.lg == LG_BUSY);
  assign error_count     = r_reg.err_cnt;
  assign error_job       = r_reg.err_job;
endmodule
`default_nettype wire

//--- dv/qdl_hub_model.sv
/*
  Behavioural model of the synchronisation hub that receives the link bits.
  Assumes the link is sampled on the logger's own clock.
*/
`timescale 1ns/1ps
`default_nettype none
module qdl_hub_model import qdl_pkg::*; (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic [NB-1:0] link_bits,
  input  wire logic [NB-1:0] link_valid,
  output logic      [NB-1:0] fwd_bits
);
  // Invalid bits are passed on as zero, so constants never reach users.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fwd_bits <= '0;
    end else begin
      fwd_bits <= link_bits & link_valid;
    end
  end
endmodule
`default_nettype wire

//--- dv/qdl_result_logger_chk.sv
/*
  Timing checks on the result logger ports.
  Assumes one clock and the asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module qdl_result_logger_chk import qdl_pkg::*; (
  input wire logic                   clk,
  input wire logic                   reset_n,
  input wire logic                   clk_en,
  input wire logic                   ms_enable,
  input wire logic [NQ-1:0]          qudit_enable,
  input wire logic [NQ-1:0][2:0]     num_states,
  input wire logic [NQ-1:0]          states_ok,
  input wire logic [NQ-1:0][1:0]     qudit_state,
  input wire logic                   packed_mode,
  input wire logic                   src_wr,
  input wire logic [NB-1:0][CW-1:0]  link_source,
  input wire logic [NB-1:0]          link_bits,
  input wire logic [NB-1:0]          link_valid,
  input wire logic                   result_enable,
  input wire logic                   trigger,
  input wire logic                   error_clear,
  input wire logic [31:0]            acquired,
  input wire logic                   result_done,
  input wire logic                   result_busy,
  input wire logic [31:0]            error_count,
  input wire logic [31:0]            error_job
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  states_range_a: assert property (clk_en |=> states_ok[1] ==
    ($past(num_states[1]) inside {[2:4]})) else $error("state count check wrong");
  holdoff_count_a: assert property (result_busy && trigger && !error_clear
    |=> error_count == $past(error_count) + 32'h1) else $error("hold-off not counted");
  holdoff_job_a: assert property (result_busy && trigger
    |=> error_job == $past(acquired)) else $error("hold-off job not latched");
  err_clear_a: assert property (error_clear && !(result_busy && trigger)
    |=> error_count == 32'h0) else $error("error count not cleared");
  fixed_one_a: assert property (link_source[2] == SRC_FIXED1
    |=> link_bits[2] && !link_valid[2]) else $error("fixed one bit wrong");
  qudit_bit_a: assert property (link_source[0] <= SRC_QUDIT_LAST |=> link_valid[0] &&
    link_bits[0] == $past(qudit_state[link_source[0][4:1]][link_source[0][0]]))
    else $error("qudit link bit wrong");
  packed_lock_a: assert property (packed_mode && $past(packed_mode) && src_wr &&
    $stable(num_states) && $stable(qudit_enable) && $stable(ms_enable)
    |=> $stable(link_source)) else $error("source changed in packed mode");
  enable_gate_a: assert property (clk_en && !result_enable
    |=> !result_busy && !result_done) else $error("logger active while disabled");
  busy_cause_a: assert property ($rose(result_busy) |-> $past(trigger))
    else $error("busy without trigger");
endmodule
bind qdl_result_logger qdl_result_logger_chk chk_u (.clk, .reset_n, .clk_en, .ms_enable,
  .qudit_enable, .num_states,
  .states_ok, .qudit_state, .packed_mode, .src_wr, .link_source, .link_bits, .link_valid,
  .result_enable, .trigger, .error_clear, .acquired, .result_done, .result_busy,
  .error_count, .error_job);
`default_nettype wire

//--- dv/qdl_result_logger_test.sv
/*
  Self-checking bench for the qudit result logger with a hub model on the link.
  Assumes the clock enable is driven here and held high except in the freeze test.
*/
`timescale 1ns/1ps
`default_nettype none
module qdl_result_logger_test;
  import qdl_pkg::*;
  typedef struct packed {logic [2:0] d; logic [47:0] p; logic [1:0] s;} qdl_row_type;
  logic clk = 1'b0;
  logic reset_n, clk_en, ms_enable, packed_mode, src_wr, result_enable, result_mode;
  logic trigger, error_clear, config_valid, result_done, result_busy;
  logic [NQ-1:0] qudit_enable, states_ok, qudit_available;
  logic [NQ-1:0][2:0] num_states;
  logic [NQ-1:0][NTHR-1:0][DW-1:0] thresholds;
  qdl_disc_in_type disc_in;
  qdl_weight_type weight_in, weight_out;
  qdl_sample_type rd_data;
  logic [NQ-1:0][1:0] qudit_state;
  logic [NQ-1:0][4:0] integ_start;
  logic [NQ-1:0][NINT-1:0] integ_list;
  logic [5:0] integ_count;
  logic [4:0] src_wr_bit;
  logic [CW-1:0] src_wr_code;
  logic [NB-1:0][CW-1:0] link_source;
  logic [NB-1:0] link_bits, link_valid, fwd_bits;
  logic [1:0] result_source;
  logic [3:0] result_qudit;
  logic [15:0] result_length, rd_addr;
  logic [31:0] result_averages, acquired, error_count, error_job, acq0;
  int bad_count = 0;
  int tests_run = 0;
  // Thresholds 0..2 are zero, 3..5 are -10, so stray use of 3..5 shows up.
  qdl_row_type rows [7] = '{'{3'h2, 48'h0000_0000_0005, 2'h1},
    '{3'h2, 48'hFFFF_FFFF_FFFF, 2'h0}, '{3'h3, 48'h0000_FFFF_FFFF, 2'h0},
    '{3'h3, 48'h0000_FFFF_0001, 2'h2}, '{3'h4, 48'hFFFF_FFFF_0001, 2'h3},
    '{3'h4, 48'hFFEC_FFEC_FFEC, 2'h0}, '{3'h4, 48'hFFEC_FFEC_FFFF, 2'h1}};
  logic [47:0] seq_p [4] = '{48'hFFFF_FFFF_0001, 48'hFFEC_FFEC_FFFF,
    48'hFFEC_FFEC_FFEC, 48'hFFFF_FFFF_0001};

  always #12.5 clk = ~clk;

  qdl_result_logger dut_u (.*);
  qdl_hub_model hub_u (.clk, .reset_n, .link_bits, .link_valid, .fwd_bits);

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wsrc(input logic [4:0] b, input logic [CW-1:0] c);
    src_wr = 1'b1;
    src_wr_bit = b;
    src_wr_code = c;
    tick(1);
  endtask
  task automatic hit(input logic [47:0] p, input logic [15:0] im);
    disc_in = {1'b1, 4'h0, p, im};
    tick(1);
    disc_in.valid = 1'b0;
  endtask
  task automatic acq(input logic [47:0] p, input logic [15:0] im);
    int n;
    n = 0;
    trigger = 1'b1;
    tick(1);
    trigger = 1'b0;
    while (result_busy !== 1'b1) begin
      if (n == 8) begin
        bad_count++;
        give_verdict();
      end
      n++;
      tick(1);
    end
    hit(p, im);
  endtask
  task automatic rd(input logic [15:0] a, input logic [63:0] exp);
    rd_addr = a;
    tick(1);
    chk(rd_data, exp);
  endtask

  initial begin
    reset_n = 1'b0; clk_en = 1'b1; ms_enable = 1'b1; packed_mode = 1'b0; src_wr = 1'b0;
    result_enable = 1'b0; result_mode = 1'b1; trigger = 1'b0; error_clear = 1'b0;
    qudit_enable = '0; num_states = {NQ{3'h3}}; src_wr_bit = '0; src_wr_code = '0;
    thresholds = {NQ{96'hFFF6_FFF6_FFF6_0000_0000_0000}};
    disc_in = '0; weight_in = '0; result_source = LOG_SRC_DISC; result_qudit = 4'h0;
    result_averages = 32'h2; result_length = 16'h2; rd_addr = '0;
    tick(8);
    chk(link_source[9], SRC_FIXED0);
    chk({link_valid, error_count}, 64'h0);
    chk(acquired, 32'h0);
    reset_n = 1'b1;
    $display("reset test done");
    wsrc(5'h0, 6'h00); wsrc(5'h1, 6'h01); wsrc(5'h2, SRC_FIXED1); wsrc(5'h3, SRC_FIXED0);
    src_wr = 1'b0;
    foreach (rows[i]) begin
      num_states[0] = rows[i].d;
      tick(2);
      hit(rows[i].p, 16'h0);
      chk(qudit_state[0], rows[i].s);
      tick(1);
      chk({link_valid[1:0], link_bits[1:0]}, {2'b11, rows[i].s});
    end
    tick(1);
    chk({link_valid[3:2], link_bits[3:2], fwd_bits[3:0]}, 8'h11);
    $display("discrimination rows done");
    qudit_enable = 16'h0002;
    for (int d = 0; d < 8; d++) begin
      num_states[1] = d[2:0];
      tick(2);
      chk({states_ok[1], config_valid}, {2{d >= 2 && d <= 4}});
    end
    num_states = {NQ{3'h3}};
    qudit_enable = 16'h00FF;
    tick(2);
    chk({config_valid, integ_count}, {1'b1, 6'h10});
    chk({integ_start[5], integ_list[5]}, {5'h0A, 16'h0C00});
    qudit_enable = 16'h01FF;
    tick(2);
    chk(config_valid, 1'b0);
    chk(qudit_available[8:7], 2'b01);
    qudit_enable = 16'h00FF; num_states[1] = 3'h2; packed_mode = 1'b1;
    tick(2);
    chk({link_source[2], link_source[3], link_source[14]}, 18'h0210F);
    chk(link_source[15], SRC_FIXED0);
    wsrc(5'h3, SRC_FIXED1);
    src_wr = 1'b0;
    tick(1);
    chk(link_source[3], 6'h04);
    packed_mode = 1'b0;
    $display("config and packing done");
    weight_in = {1'b1, 4'h2, 2'h0, 16'h8000, 16'h1234};
    tick(1);
    chk(weight_out, {1'b1, 4'h2, 2'h0, 16'h8001, 16'h1234});
    weight_in = {1'b1, 4'h2, 2'h2, 16'h0100, 16'h0100};
    tick(1);
    weight_in.valid = 1'b0;
    chk(weight_out.valid, 1'b0);
    $display("weights done");
    num_states[0] = 3'h4; result_enable = 1'b1;
    tick(2);
    acq0 = acquired;
    for (int i = 0; i < 4; i++) begin
      acq(seq_p[i], 16'h0);
      chk(acquired, acq0 + 32'(i + 1));
    end
    chk(result_done, 1'b1);
    rd(16'h0, 64'h4_0000_0000);
    rd(16'h1, 64'h3_0000_0000);
    $display("sequential logging done");
    result_enable = 1'b0;
    tick(1);
    result_mode = 1'b0; result_source = LOG_SRC_INTEG; result_enable = 1'b1;
    tick(2);
    acq(48'h5, 16'hFFFE); acq(48'h7, 16'h3);
    trigger = 1'b1;
    tick(2);
    trigger = 1'b0;
    tick(1);
    chk({error_count, error_job}, {32'h1, acq0 + 32'h6});
    hit(48'h1, 16'h0);
    acq(48'h9, 16'h4);
    chk({result_done, acquired}, {1'b1, acq0 + 32'h8});
    rd(16'h0, {32'h6, 32'hFFFF_FFFE});
    rd(16'h1, {32'h10, 32'h7});
    error_clear = 1'b1;
    tick(1);
    error_clear = 1'b0;
    chk(error_count, 32'h0);
    result_enable = 1'b0;
    tick(1);
    trigger = 1'b1;
    tick(1);
    trigger = 1'b0;
    hit(48'h1, 16'h0);
    chk({result_busy, acquired}, {1'b0, acq0 + 32'h8});
    $display("cyclic logging and hold-off done");
    tick(2);
    clk_en = 1'b0;
    num_states[1] = 3'h7;
    tick(2);
    chk(states_ok[1], 1'b1);
    clk_en = 1'b1;
    tick(2);
    chk(states_ok[1], 1'b0);
    $display("clock enable freeze done");
    give_verdict();
  end
endmodule
`default_nettype wire
